/* rtl/eeprom_pkg.sv */
// constants for the serial nonvolatile memory write and hold logic
package eeprom_pkg;
  localparam int clock_hz = 50000000;
  // opcodes, most significant bit first
  localparam logic [7:0] op_latch_set = 8'h06;
  localparam logic [7:0] op_latch_clear = 8'h04;
  localparam logic [7:0] op_status_read = 8'h05;
  localparam logic [7:0] op_status_write = 8'h01;
  localparam logic [7:0] op_array_read = 8'h03;
  localparam logic [7:0] op_array_write = 8'h02;
  localparam logic [7:0] op_addr_mask = 8'hf7;
  localparam int addr_opcode_bit = 3;
  // status byte layout
  localparam int busy_bit = 0;
  localparam int latch_bit = 1;
  localparam int protect_lo_bit = 2;
  localparam int protect_hi_bit = 3;
  localparam logic [1:0] protect_reset = 2'h0;
  // page and array geometry
  localparam int page_bytes = 4;
  localparam int addr_width = 9;
  // write cycle time, longest, in microseconds
  localparam int write_time_us = 10000;
  localparam int write_cycles = write_time_us * (clock_hz / 1000000);
endpackage

/* rtl/pin_sync.sv */
// three-stage input synchroniser for pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int width = 1,
  parameter logic [width-1:0] init = '0
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pins in, settled value out
  input wire logic [width-1:0] pin,
  output logic [width-1:0] level
);
  logic [width-1:0] stage1;
  logic [width-1:0] stage2;
  logic [width-1:0] stage3;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= init;
      stage2 <= init;
      stage3 <= init;
      level <= init;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      // a bit changes only once second and third stages agree
      for (int i = 0; i < width; i++) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/eeprom_write_ctrl.sv */
// serial nonvolatile memory write, status and hold sequencing
`timescale 1ns/10ps
`default_nettype none
module eeprom_write_ctrl #(
  parameter int write_cycles = eeprom_pkg::write_cycles,
  parameter int page_bytes = eeprom_pkg::page_bytes
) (
  // clock and reset (reset stands for power-up)
  input wire logic clock,
  input wire logic rst,
  // serial pins
  input wire logic select_n,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic hold_n,
  input wire logic write_protect_n,
  output logic serial_out,
  output logic serial_out_en,
  // memory array write port, read port
  output logic mem_write,
  output logic [eeprom_pkg::addr_width-1:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // status
  output logic busy_flag,
  output logic latch_flag,
  output logic protect_level_low_bit,
  output logic protect_level_high_bit
);
  if (page_bytes != 4 || write_cycles < 1) begin
    $error("unsupported page size or write time");
  end

  typedef enum {st_idle, st_opcode, st_address, st_data, st_status_data, st_shift_out, st_ignore} state_t;

  localparam int aw = eeprom_pkg::addr_width;

  function automatic logic is_protected(input logic [1:0] level, input logic [aw-1:0] a);
    case (level)
      2'h1: is_protected = (a[8:7] == 2'h3);
      2'h2: is_protected = a[8];
      2'h3: is_protected = 1'b1;
      default: is_protected = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // pin sampling
  logic sel_n;
  logic sck;
  logic sdi;
  logic hold_low_n;
  logic wp_n;
  logic sck_d;
  logic sel_d;
  logic armed;

  // select and clock start low: a select held low over power-up gives no falling edge
  pin_sync #(.width(5), .init(5'h03)) u_sync (
    .clock(clock),
    .rst(rst),
    .pin({select_n, serial_clock, serial_in, hold_n, write_protect_n}),
    .level({sel_n, sck, sdi, hold_low_n, wp_n})
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sck_d <= 1'b0;
      sel_d <= 1'b0;
    end else begin
      sck_d <= sck;
      sel_d <= sel_n;
    end
  end

  // clock edges count only while selected and not held
  wire active = !sel_n && hold_low_n && armed;
  wire sck_rise = active && sck && !sck_d;
  wire sck_fall = active && !sck && sck_d;
  wire sel_fall = sel_d && !sel_n;
  wire sel_rise = !sel_d && sel_n;

  // no instruction accepted until a select falling edge after power-up
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (sel_fall) begin
      armed <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // serial shifter and sequencer
  state_t state;
  logic [2:0] bit_count;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [7:0] opcode;
  logic [aw-1:0] addr;
  logic [1:0] page_offset;
  logic [2:0] byte_count;
  logic byte_done;
  logic [7:0] page_buf [page_bytes];
  logic [3:0] page_valid;
  logic [1:0] protect;
  logic [7:0] status_new;
  logic [7:0] status_byte;
  wire [7:0] rx_byte = {shift_in[6:0], sdi};

  // busy reads with all upper bits set during a write
  assign status_byte = busy_flag ? 8'hff :
    {4'h0, protect[1], protect[0], latch_flag, 1'b0};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      bit_count <= 3'h0;
      shift_in <= 8'h00;
      opcode <= 8'h00;
      addr <= '0;
      page_offset <= 2'h0;
      byte_count <= 3'h0;
      byte_done <= 1'b0;
      page_valid <= 4'h0;
      status_new <= 8'h00;
    end else if (sel_n) begin
      state <= st_idle;
      bit_count <= 3'h0;
    end else if (sck_rise) begin
      shift_in <= rx_byte;
      bit_count <= bit_count + 3'h1;
      byte_done <= (bit_count == 3'h7);
      if (bit_count == 3'h7) begin
        case (state)
          st_idle, st_opcode: begin
            opcode <= rx_byte;
            byte_count <= 3'h0;
            page_valid <= 4'h0;
            if ((rx_byte & eeprom_pkg::op_addr_mask) == eeprom_pkg::op_array_write ||
                (rx_byte & eeprom_pkg::op_addr_mask) == eeprom_pkg::op_array_read) begin
              state <= st_address;
            end else if (rx_byte == eeprom_pkg::op_status_write) begin
              state <= st_status_data;
            end else if (rx_byte == eeprom_pkg::op_status_read) begin
              state <= st_shift_out;
            end else begin
              // after latch set or clear the host must deselect
              state <= st_ignore;
            end
          end
          st_address: begin
            addr <= {opcode[eeprom_pkg::addr_opcode_bit], rx_byte};
            page_offset <= rx_byte[1:0];
            state <= (opcode[0]) ? st_shift_out : st_data;
          end
          st_data: begin
            page_buf[page_offset] <= rx_byte;
            page_valid[page_offset] <= 1'b1;
            page_offset <= page_offset + 2'h1;
            if (byte_count != 3'h4) begin
              byte_count <= byte_count + 3'h1;
            end
          end
          st_status_data: begin
            status_new <= rx_byte;
            byte_count <= 3'h1;
            state <= st_ignore;
          end
          // a byte past a latch or status command spoils its commit
          st_ignore: byte_count <= 3'h7;
          default: state <= state;
        endcase
      end
    end else if (sck_fall && state != st_idle && bit_count != 3'h0) begin
      byte_done <= 1'b0; // a following bit has started
    end
  end

  ////////////////////////////////////////////////////////////////////
  // latch, protection and self-timed write
  wire [aw-1:0] page_base = {addr[aw-1:2], 2'h0};
  wire array_commit = sel_rise && (state == st_data) && byte_done && bit_count == 3'h0 && byte_count != 3'h0;
  wire status_commit = sel_rise && opcode == eeprom_pkg::op_status_write && byte_done &&
    bit_count == 3'h0 && byte_count == 3'h1;
  wire allowed = latch_flag && wp_n && !busy_flag && !is_protected(protect, addr);
  wire status_allowed = latch_flag && wp_n && !busy_flag;
  logic [31:0] wait_count;
  logic writing_status;
  logic [2:0] flush;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latch_flag <= 1'b0;
      busy_flag <= 1'b0;
      wait_count <= 32'h0;
      writing_status <= 1'b0;
      protect <= eeprom_pkg::protect_reset;
      flush <= 3'h0;
    end else if (busy_flag) begin
      if (wait_count == 32'(write_cycles - 1)) begin
        busy_flag <= 1'b0;
        latch_flag <= 1'b0;
        if (writing_status) begin
          protect <= status_new[eeprom_pkg::protect_hi_bit:eeprom_pkg::protect_lo_bit];
        end
      end
      wait_count <= wait_count + 32'h1;
      if (flush != 3'h4) begin
        flush <= flush + 3'h1;
      end
    end else if (array_commit && allowed) begin
      busy_flag <= 1'b1;
      wait_count <= 32'h0;
      writing_status <= 1'b0;
      flush <= 3'h0;
    end else if (status_commit && status_allowed) begin
      busy_flag <= 1'b1;
      wait_count <= 32'h0;
      writing_status <= 1'b1;
      flush <= 3'h4;
    end else if (sel_rise && byte_done && bit_count == 3'h0 && state == st_ignore &&
                 byte_count == 3'h0) begin
      if (opcode == eeprom_pkg::op_latch_set) begin
        latch_flag <= 1'b1;
      end else if (opcode == eeprom_pkg::op_latch_clear) begin
        latch_flag <= 1'b0;
      end
    end
  end

  // loaded page bytes go to the array one per cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_write <= 1'b0;
      mem_addr <= '0;
      mem_wdata <= 8'h00;
    end else begin
      mem_write <= busy_flag && flush != 3'h4 && page_valid[flush[1:0]];
      mem_addr <= busy_flag ? (page_base | aw'(flush[1:0])) : addr;
      mem_wdata <= page_buf[flush[1:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // serial output, driven on falling clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_out <= 8'h00;
      serial_out <= 1'b0;
      serial_out_en <= 1'b0;
      protect_level_low_bit <= 1'b0;
      protect_level_high_bit <= 1'b0;
    end else begin
      protect_level_low_bit <= protect[0];
      protect_level_high_bit <= protect[1];
      serial_out_en <= !sel_n && hold_low_n && state == st_shift_out;
      if (sck_fall && state == st_shift_out) begin
        if (bit_count == 3'h0) begin
          serial_out <= opcode == eeprom_pkg::op_status_read ? status_byte[7] : mem_rdata[7];
          shift_out <= opcode == eeprom_pkg::op_status_read ? {status_byte[6:0], 1'b0} :
            {mem_rdata[6:0], 1'b0};
        end else begin
          serial_out <= shift_out[7];
          shift_out <= {shift_out[6:0], 1'b0};
        end
      end
    end
  end
endmodule
`default_nettype wire

/* bench/eeprom_write_monitor.sv */
// timing checks on the memory write and hold logic ports
`timescale 1ns/10ps
`default_nettype none
module eeprom_write_monitor #(
  parameter int write_cycles = 200
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // pins
  input wire logic select_n,
  input wire logic hold_n,
  input wire logic write_protect_n,
  input wire logic serial_out_en,
  // array and status
  input wire logic mem_write,
  input wire logic busy_flag,
  input wire logic latch_flag,
  input wire logic protect_level_low_bit,
  input wire logic protect_level_high_bit
);
  int busy_len;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_flag ? busy_len + 1 : 0;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  power_up_clear_a: assert property ($fell(rst) |-> !latch_flag && !busy_flag && !serial_out_en)
    else $error("state not clear after power-up");
  write_time_a: assert property (busy_flag |-> busy_len < write_cycles + 2)
    else $error("write cycle too long");
  latch_auto_clear_a: assert property ($fell(busy_flag) |-> ##[0:2] !latch_flag)
    else $error("latch not cleared after write");
  start_needs_latch_a: assert property ($rose(busy_flag) |-> latch_flag && write_protect_n)
    else $error("write started while blocked");
  start_on_deselect_a: assert property ($rose(busy_flag) |-> select_n && $past(select_n, 2))
    else $error("write started without deselect");
  array_write_busy_a: assert property (mem_write |-> busy_flag)
    else $error("array written outside write cycle");
  full_protect_a: assert property (mem_write |-> !(protect_level_low_bit && protect_level_high_bit))
    else $error("write into protected array");
  hold_release_a: assert property (!hold_n [*6] |-> !serial_out_en)
    else $error("output driven during hold");
  drive_start_a: assert property ($rose(serial_out_en) |-> !select_n && hold_n)
    else $error("output enabled while idle or held");
endmodule
`default_nettype wire

/* bench/spi_host_model.sv */
// serial host model driving the memory pins
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // clock
  input wire logic clock,
  // serial pins
  output logic select_n,
  output logic serial_clock,
  output logic serial_in,
  output logic hold_n,
  input wire logic serial_out
);
  logic hold_bit = 1'b0;
  // select starts low so the first frame lacks a falling edge
  initial begin
    select_n = 1'b0;
    serial_clock = 1'b0;
    serial_in = 1'b0;
    hold_n = 1'b1;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic frame_start;
    select_n = 1'b0;
    idle(8);
  endtask
  task automatic frame_end;
    idle(8);
    select_n = 1'b1;
    serial_in = ~serial_in;
    idle(16);
  endtask
  // one byte msb first, optional pause in mid-byte
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      serial_in = tx[i];
      idle(4);
      if (hold_bit && i == 4) begin
        hold_n = 1'b0;
        idle(24);
        hold_n = 1'b1;
        idle(8);
      end
      serial_clock = 1'b1;
      idle(4);
      rx[i] = serial_out;
      serial_clock = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// testbench for the memory write and hold logic
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t %h %h", $time, a, b); end end
module tb_top;
  logic clock, rst, write_protect_n, serial_out, serial_out_en, mem_write;
  wire logic select_n, serial_clock, serial_in, hold_n;
  logic busy_flag, latch_flag, protect_level_low_bit, protect_level_high_bit;
  logic [8:0] mem_addr;
  logic [7:0] mem_wdata, rx, st;
  logic [7:0] mem [512];
  int miscompares = 0;
  int check_count = 0;
  wire logic [7:0] mem_rdata = mem[mem_addr];
  always @(posedge clock) if (mem_write) mem[mem_addr] <= mem_wdata;
  eeprom_write_ctrl #(.write_cycles(200), .page_bytes(4)) dut_u (.clock, .rst, .select_n, .serial_clock,
    .serial_in, .hold_n, .write_protect_n, .serial_out, .serial_out_en, .mem_write, .mem_addr, .mem_wdata,
    .mem_rdata, .busy_flag, .latch_flag, .protect_level_low_bit, .protect_level_high_bit);
  // a released output shows the inverse of its last value
  wire logic so_line = serial_out_en ? serial_out : ~serial_out;
  spi_host_model host_u (.clock, .select_n, .serial_clock, .serial_in, .hold_n, .serial_out(so_line));
  //////////////////////////////////////////////////////////////////
  task automatic op(input logic [7:0] code);
    host_u.frame_start;
    host_u.xfer(code, rx);
    host_u.frame_end;
  endtask
  task automatic status;
    host_u.frame_start;
    host_u.xfer(eeprom_pkg::op_status_read, rx);
    host_u.xfer(8'h00, st);
    host_u.frame_end;
  endtask
  // array write of n bytes a0, a1, ..., optionally after latch set in the same frame
  task automatic write(input logic [8:0] a, input int n, input logic pre);
    host_u.frame_start;
    if (pre) host_u.xfer(eeprom_pkg::op_latch_set, rx);
    host_u.xfer(eeprom_pkg::op_array_write | {4'h0, a[8], 3'h0}, rx);
    host_u.xfer(a[7:0], rx);
    for (int k = 0; k < n; k++) host_u.xfer(8'ha0 + 8'(k), rx);
    host_u.frame_end;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 400 && busy_flag !== 1'b0; i++) @(negedge clock);
    repeat (2) @(negedge clock);
    `CHK(busy_flag, 1'b0)
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    rst = 1'b1;
    write_protect_n = 1'b1;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    // power-up wait, scaled like the write time
    host_u.idle(100);
    host_u.xfer(eeprom_pkg::op_latch_set, rx);
    host_u.frame_end;
    `CHK(latch_flag, 1'b0)
    status;
    `CHK(st, 8'h00)
    op(eeprom_pkg::op_latch_set);
    `CHK(latch_flag, 1'b1)
    op(eeprom_pkg::op_latch_clear);
    `CHK(latch_flag, 1'b0)
    write(9'h105, 2, 1'b0);
    `CHK(busy_flag, 1'b0)
    write(9'h105, 2, 1'b1);
    `CHK(busy_flag, 1'b0)
    `CHK(latch_flag, 1'b0)
    op(eeprom_pkg::op_latch_set);
    write(9'h105, 0, 1'b0);
    `CHK(busy_flag, 1'b0)
    op(eeprom_pkg::op_latch_set);
    write_protect_n = 1'b0;
    write(9'h105, 1, 1'b0);
    `CHK(busy_flag, 1'b0)
    write_protect_n = 1'b1;
    op(eeprom_pkg::op_latch_set);
    write(9'h105, 5, 1'b0);
    `CHK(busy_flag, 1'b1)
    status;
    `CHK(st, 8'hff)
    wait_idle;
    `CHK(latch_flag, 1'b0)
    `CHK({mem[9'h104], mem[9'h105], mem[9'h106], mem[9'h107]}, 32'ha3a4a1a2)
    `CHK(mem[9'h005], 8'h00)
    // array read back of the first page byte
    host_u.frame_start;
    host_u.xfer(eeprom_pkg::op_array_read | 8'h08, rx);
    host_u.xfer(8'h04, rx);
    host_u.xfer(8'h00, st);
    host_u.frame_end;
    `CHK(st, 8'ha3)
    op(eeprom_pkg::op_latch_set);
    host_u.frame_start;
    host_u.xfer(eeprom_pkg::op_status_write, rx);
    host_u.xfer(8'h08, rx);
    host_u.frame_end;
    wait_idle;
    `CHK({protect_level_high_bit, protect_level_low_bit}, 2'h2)
    host_u.hold_bit = 1'b1;
    status;
    host_u.hold_bit = 1'b0;
    `CHK(st, 8'h08)
    op(eeprom_pkg::op_latch_set);
    write(9'h1fe, 1, 1'b0);
    `CHK(busy_flag, 1'b0)
    tally_and_finish;
  end
endmodule
bind eeprom_write_ctrl eeprom_write_monitor #(.write_cycles(write_cycles)) mon_u (.clock, .rst, .select_n,
  .hold_n, .write_protect_n, .serial_out_en, .mem_write, .busy_flag, .latch_flag, .protect_level_low_bit,
  .protect_level_high_bit);
`default_nettype wire
